// file: dacuc_regs.vh
// Register addresses, field positions, reset values and write mask of the
// update/clear/reset controller. Included by both design files.
`ifndef DACUC_REGS_VH
`define DACUC_REGS_VH

`define DACUC_FRAME_BITS     24
`define DACUC_RW_BIT         23
`define DACUC_ADDR_HI        22
`define DACUC_ADDR_LO        20
`define DACUC_DATA_HI        19
`define DACUC_CODE_LO        2

`define DACUC_ADDR_NOP       3'h0
`define DACUC_ADDR_CODE      3'h1
`define DACUC_ADDR_CTRL      3'h2
`define DACUC_ADDR_CLEAR     3'h3
`define DACUC_ADDR_SWCTRL    3'h4

`define DACUC_CTRL_AMP       1
`define DACUC_CTRL_CLAMP     2
`define DACUC_CTRL_FLOAT     3
`define DACUC_CTRL_FMT       4
`define DACUC_CTRL_SERIAL_OUT_DISABLE    5
`define DACUC_CTRL_LIN_HI    9
`define DACUC_CTRL_LIN_LO    6

`define DACUC_SW_LOAD        0
`define DACUC_SW_CLEAR       1
`define DACUC_SW_RESET       2

`define DACUC_CODE_RST       18'h00000
`define DACUC_CTRL_RST       20'h0000E
`define DACUC_CTRL_WMASK     20'h003FE

`endif

// file: dacuc_code_store.v
// Holds the converter code and clearcode words; read data comes from a register.
// Assumes writes and reads on the system clock; reset loads defaults.
`timescale 1ns/100ps
`include "dacuc_regs.vh"
module dacuc_code_store (
  input  wire        clock,
  input  wire        rstn,
  input  wire        srst,
  input  wire        we,
  input  wire        waddr,
  input  wire [17:0] wdata,
  input  wire        raddr,
  output reg  [17:0] rdata
);
  // Each word has its own register so that every word has a single driver
  wire [17:0] word [0:1];
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_word
      reg [17:0] word_q;
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          word_q <= `DACUC_CODE_RST;
        end else if (srst) begin
          word_q <= `DACUC_CODE_RST;
        end else if (we && (waddr == i)) begin
          word_q <= wdata;
        end
      end
      assign word[i] = word_q;
    end
  endgenerate

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= `DACUC_CODE_RST;
    end else begin
      rdata <= word[raddr];
    end
  end
endmodule

// file: dacuc_core.v
// Serial-input converter controller: frame shift, register writes,
// load/clear/reset pins and software control, output code and analog controls.
// Assumes pins are asynchronous to clock; serial clock is sampled, not used as clock.
`timescale 1ns/100ps
`include "dacuc_regs.vh"
module dacuc_core (
  input  wire        clock,
  input  wire        rstn,
  input  wire        reset_pin_n,
  input  wire        load_strobe_n,
  input  wire        clear_strobe,
  input  wire        frame_select_n,
  input  wire        serial_clk,
  input  wire        serial_data_in,
  output reg         serial_data_out,
  output wire        serial_data_out_oe,
  output reg  [17:0] output_code,
  output reg         output_clamp,
  output reg         converter_tristate,
  output reg         amp_powered,
  output reg         offset_binary,
  output reg  [3:0]  lin_comp
);
  // Two-flop synchronisers for all pins
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg [5:0] prev_q;
  wire [5:0] pin_raw = {reset_pin_n, load_strobe_n, clear_strobe,
                        frame_select_n, serial_clk, serial_data_in};
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
      prev_q  <= 6'h3F;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire rst_s   = sync2_q[5];
  wire load_s  = sync2_q[4];
  wire clr_s   = sync2_q[3];
  wire fs_s    = sync2_q[2];
  wire sclk_s  = sync2_q[1];
  wire sdi_s   = sync2_q[0];
  wire rst_rise  = rst_s & ~prev_q[5];
  wire load_fall = ~load_s & prev_q[4];
  wire fs_fall   = ~fs_s & prev_q[2];
  wire fs_rise   = fs_s & ~prev_q[2];
  wire sclk_fall = ~sclk_s & prev_q[1];
  wire sclk_rise = sclk_s & ~prev_q[1];

  // Internal soft reset: held while reset pin low, pulsed on release and sw reset
  reg  sw_reset_q;
  wire in_reset = ~rst_s;
  wire srst     = in_reset | rst_rise | sw_reset_q;

  // Serial frame shift: sample on falling serial clock edges
  reg [23:0] shift_q;
  reg [4:0]  count_q;
  reg        in_frame_q;
  reg [23:0] rd_shift_q;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q    <= 24'h000000;
      count_q    <= 5'h00;
      in_frame_q <= 1'b0;
    end else if (srst) begin
      shift_q    <= 24'h000000;
      count_q    <= 5'h00;
      in_frame_q <= 1'b0;
    end else if (fs_fall) begin
      count_q    <= 5'h00;
      in_frame_q <= 1'b1;
    end else if (fs_rise) begin
      in_frame_q <= 1'b0;
    end else if (in_frame_q && sclk_fall) begin
      shift_q <= {shift_q[22:0], sdi_s};
      if (count_q != 5'h1F) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // Frame is valid only with exactly 24 falling serial clock edges
  wire        frame_ok  = fs_rise && in_frame_q && (count_q == 5'h18);
  wire        fr_write  = frame_ok && !shift_q[`DACUC_RW_BIT];
  wire        fr_read   = frame_ok && shift_q[`DACUC_RW_BIT];
  wire [2:0]  fr_addr   = shift_q[`DACUC_ADDR_HI:`DACUC_ADDR_LO];
  wire [19:0] fr_data   = shift_q[`DACUC_DATA_HI:0];
  wire [17:0] fr_code   = fr_data[19:`DACUC_CODE_LO];

  // Control register
  reg [19:0] ctrl_q;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `DACUC_CTRL_RST;
    end else if (srst) begin
      ctrl_q <= `DACUC_CTRL_RST;
    end else if (fr_write && fr_addr == `DACUC_ADDR_CTRL) begin
      ctrl_q <= fr_data & `DACUC_CTRL_WMASK;
    end
  end

  // Software control bits act as one-shot pin pulses; load needs clear pin high, clear needs load pin high
  wire sw_wr    = fr_write && (fr_addr == `DACUC_ADDR_SWCTRL);
  wire sw_load  = sw_wr && fr_data[`DACUC_SW_LOAD] && clr_s;
  wire sw_clear = sw_wr && fr_data[`DACUC_SW_CLEAR] && load_s;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= sw_wr && fr_data[`DACUC_SW_RESET] && !sw_reset_q;
    end
  end

  // Input register holds code written but not yet applied
  reg [17:0] input_q;
  reg        pend_q;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      input_q <= `DACUC_CODE_RST;
      pend_q  <= 1'b0;
    end else if (srst) begin
      input_q <= `DACUC_CODE_RST;
      pend_q  <= 1'b0;
    end else if (fr_write && fr_addr == `DACUC_ADDR_CODE) begin
      input_q <= fr_code;
      pend_q  <= 1'b1;
    end
  end

  // Clear source: pin low or a software clear
  wire clear_act = ~clr_s | sw_clear;
  // Update events; clear always has priority
  wire upd_sync  = fr_write && (fr_addr == `DACUC_ADDR_CODE) && !load_s;
  wire upd_async = (load_fall || sw_load) && pend_q;

  // Code store: word 0 = converter code, word 1 = clearcode
  reg  [17:0] code_q;
  reg  [17:0] clear_q;
  wire        st_we    = !srst && (clear_act ||
                          (fr_write && fr_addr == `DACUC_ADDR_CLEAR) ||
                          upd_sync || upd_async);
  wire        st_waddr = !clear_act && fr_write && (fr_addr == `DACUC_ADDR_CLEAR);
  reg  [17:0] st_wdata;
  always @* begin
    if (clear_act) begin
      st_wdata = clear_q;
    end else if (st_waddr) begin
      st_wdata = fr_code;
    end else if (upd_sync) begin
      st_wdata = fr_code;
    end else begin
      st_wdata = input_q;
    end
  end
  // Clearcode written while clear is active is applied next cycle; kept in shadow
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clear_q <= `DACUC_CODE_RST;
      code_q  <= `DACUC_CODE_RST;
    end else if (srst) begin
      clear_q <= `DACUC_CODE_RST;
      code_q  <= `DACUC_CODE_RST;
    end else begin
      if (fr_write && fr_addr == `DACUC_ADDR_CLEAR) begin
        clear_q <= fr_code;
      end
      if (clear_act) begin
        code_q <= clear_q;
      end else if (upd_sync || upd_async) begin
        code_q <= st_wdata;
      end
    end
  end

  wire [17:0] rd_word;
  reg         rd_sel_q;
  dacuc_code_store dacuc_code_store_i (
    .clock (clock),
    .rstn  (rstn),
    .srst  (srst),
    .we    (st_we),
    .waddr (st_waddr),
    .wdata (st_wdata),
    .raddr (rd_sel_q),
    .rdata (rd_word)
  );

  // Readback: next frame shifts out the addressed register on rising edges
  reg [2:0] rd_addr_q;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_addr_q <= `DACUC_ADDR_NOP;
      rd_sel_q  <= 1'b0;
    end else if (fr_read) begin
      rd_addr_q <= fr_addr;
      rd_sel_q  <= (fr_addr == `DACUC_ADDR_CLEAR);
    end else if (fs_fall) begin
      rd_addr_q <= `DACUC_ADDR_NOP;
    end
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_shift_q      <= 24'h000000;
      serial_data_out <= 1'b0;
    end else if (fs_fall) begin
      case (rd_addr_q)
        `DACUC_ADDR_CODE:  rd_shift_q <= {1'b1, rd_addr_q, rd_word, 2'h0};
        `DACUC_ADDR_CLEAR: rd_shift_q <= {1'b1, rd_addr_q, rd_word, 2'h0};
        `DACUC_ADDR_CTRL:  rd_shift_q <= {1'b1, rd_addr_q, ctrl_q};
        default:           rd_shift_q <= 24'h000000;
      endcase
      serial_data_out <= 1'b0;
    end else if (in_frame_q && sclk_rise) begin
      serial_data_out <= rd_shift_q[23];
      rd_shift_q      <= {rd_shift_q[22:0], 1'b0};
    end
  end
  assign serial_data_out_oe = in_frame_q && !ctrl_q[`DACUC_CTRL_SERIAL_OUT_DISABLE];

  // Analog controls, registered
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      output_code        <= `DACUC_CODE_RST;
      output_clamp       <= 1'b1;
      converter_tristate <= 1'b1;
      amp_powered        <= 1'b0;
      offset_binary      <= 1'b0;
      lin_comp           <= 4'h0;
    end else begin
      output_code        <= code_q;
      output_clamp       <= ctrl_q[`DACUC_CTRL_CLAMP];
      converter_tristate <= ctrl_q[`DACUC_CTRL_CLAMP] | ctrl_q[`DACUC_CTRL_FLOAT];
      amp_powered        <= ~ctrl_q[`DACUC_CTRL_AMP];
      offset_binary      <= ctrl_q[`DACUC_CTRL_FMT];
      lin_comp           <= ctrl_q[`DACUC_CTRL_LIN_HI:`DACUC_CTRL_LIN_LO];
    end
  end
endmodule

// file: dacuc_host.sv
// Host-side driver for the controller's serial frame pins.
// Assumes frames are started from idle; timing is in ns, unrelated to the clock.
`timescale 1ns/100ps
module dacuc_host (
  output reg        serial_clk,
  output reg        frame_select_n,
  output reg        serial_data_in,
  input  wire       serial_data_out,
  input  wire       serial_data_out_oe,
  output reg [23:0] sdo_word,
  output reg        oe_seen
);
  initial begin
    serial_clk     = 1'h1;
    frame_select_n = 1'h1;
    serial_data_in = 1'h0;
    sdo_word       = 24'h000000;
    oe_seen        = 1'h0;
  end
  // Sends the top n bits of w, MSB first; slow stretches the frame end.
  // Readback bits are taken on the falling edge after each rising-edge launch; the last one at frame end.
  task send(input [23:0] w, input integer n, input integer slow);
    integer i;
    begin
      frame_select_n = 1'h0;
      oe_seen        = 1'h1;
      for (i = 23; i > 23 - n; i = i - 1) begin
        serial_data_in = w[i];
        #62.5 serial_clk = 1'h0;
        if (i < 23)
          sdo_word = {sdo_word[22:0], serial_data_out};
        oe_seen = oe_seen & serial_data_out_oe;
        #62.5 serial_clk = 1'h1;
      end
      #(62.5 + slow) sdo_word = {sdo_word[22:0], serial_data_out};
      frame_select_n = 1'h1;
      // Released data line must not look like a held value
      serial_data_in = ~serial_data_in;
    end
  endtask
endmodule

// file: dacuc_core_properties.sv
// Pin-level checks for the update/clear/reset controller.
// Assumes it is bound into dacuc_core and sees only its ports.
`timescale 1ns/100ps
module dacuc_core_properties (
  input wire        clock,
  input wire        rstn,
  input wire        reset_pin_n,
  input wire        load_strobe_n,
  input wire        clear_strobe,
  input wire        frame_select_n,
  input wire        serial_clk,
  input wire        serial_data_in,
  input wire        serial_data_out,
  input wire        serial_data_out_oe,
  input wire [17:0] output_code,
  input wire        output_clamp,
  input wire        converter_tristate,
  input wire        amp_powered,
  input wire        offset_binary,
  input wire [3:0]  lin_comp
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_por_clamped:
    assert property (!$past(rstn) |-> output_clamp && converter_tristate && output_code == 18'h0)
    else $error("not clamped after reset");
  a_clamp_tristates:
    assert property (output_clamp |-> converter_tristate) else $error("clamp without tristate");
  a_pin_reset_code:
    assert property (!reset_pin_n [*8] |-> output_code == 18'h0) else $error("code not reset");
  a_pin_reset_ctrl:
    assert property (!reset_pin_n [*8] |-> output_clamp && !amp_powered && !offset_binary)
    else $error("control not reset");
  a_pin_reset_lin:
    assert property (!reset_pin_n [*8] |-> lin_comp == 4'h0 && converter_tristate)
    else $error("fields not reset");
  a_clear_blocks:
    assert property ((!clear_strobe && reset_pin_n) [*8] |-> $stable(output_code))
    else $error("code moved while cleared");
  a_frame_holds:
    assert property ((!frame_select_n && clear_strobe && reset_pin_n) [*8]
      |-> $stable(output_code)) else $error("code moved inside frame");
  a_idle_holds:
    assert property ((frame_select_n && clear_strobe && reset_pin_n && $stable(load_strobe_n))
      [*8] |-> $stable(output_code)) else $error("code moved while idle");
  c_clear: cover property (!clear_strobe [*8]);
  c_pin_reset: cover property (!reset_pin_n [*8]);
  c_update: cover property ($changed(output_code) && !output_clamp);
endmodule
bind dacuc_core dacuc_core_properties dacuc_core_properties_i (
  .clock              (clock),
  .rstn               (rstn),
  .reset_pin_n        (reset_pin_n),
  .load_strobe_n      (load_strobe_n),
  .clear_strobe       (clear_strobe),
  .frame_select_n     (frame_select_n),
  .serial_clk         (serial_clk),
  .serial_data_in     (serial_data_in),
  .serial_data_out    (serial_data_out),
  .serial_data_out_oe (serial_data_out_oe),
  .output_code        (output_code),
  .output_clamp       (output_clamp),
  .converter_tristate (converter_tristate),
  .amp_powered        (amp_powered),
  .offset_binary      (offset_binary),
  .lin_comp           (lin_comp)
);

// file: dacuc_core_test.sv
// Self-checking bench for the update/clear/reset controller.
// Assumes dacuc_host drives the frames; a reference model tracks the outputs.
`timescale 1ns/100ps
module dacuc_core_test;
  reg         clock = 1'h0;
  reg         rstn = 1'h0;
  reg         reset_pin_n = 1'h1;
  reg         load_strobe_n = 1'h1;
  reg         clear_strobe = 1'h1;
  wire        frame_select_n, serial_clk, serial_data_in, serial_data_out, serial_data_out_oe;
  wire        output_clamp, converter_tristate, amp_powered, offset_binary;
  wire [17:0] output_code;
  wire [3:0]  lin_comp;
  wire [23:0] sdo_word;
  wire        oe_seen;
  reg  [31:0] rs = 32'h0000EBE8;
  reg  [17:0] e_code, e_clr, e_in;
  reg  [19:0] e_ctrl;
  integer     err_count = 0;
  integer     n_checks = 0;
  integer     i;
  dacuc_core dacuc_core_i (
    .clock              (clock),
    .rstn               (rstn),
    .reset_pin_n        (reset_pin_n),
    .load_strobe_n      (load_strobe_n),
    .clear_strobe       (clear_strobe),
    .frame_select_n     (frame_select_n),
    .serial_clk         (serial_clk),
    .serial_data_in     (serial_data_in),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .output_code        (output_code),
    .output_clamp       (output_clamp),
    .converter_tristate (converter_tristate),
    .amp_powered        (amp_powered),
    .offset_binary      (offset_binary),
    .lin_comp           (lin_comp)
  );
  dacuc_host dacuc_host_i (
    .serial_clk         (serial_clk),
    .frame_select_n     (frame_select_n),
    .serial_data_in     (serial_data_in),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .sdo_word           (sdo_word),
    .oe_seen            (oe_seen)
  );
  always #5 clock = ~clock;
  function automatic [31:0] nxt();
    begin
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      nxt = rs;
    end
  endfunction
  task rst_model;
    begin
      e_code = 18'h0;
      e_clr = 18'h0;
      e_in = 18'h0;
      e_ctrl = 20'h0000E;
    end
  endtask
  task chk;
    begin
      n_checks = n_checks + 1;
      if (output_code !== e_code || output_clamp !== e_ctrl[2]
          || converter_tristate !== (e_ctrl[2] | e_ctrl[3]) || amp_powered !== ~e_ctrl[1]
          || offset_binary !== e_ctrl[4] || lin_comp !== e_ctrl[9:6]) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t code %h expected %h", $time, output_code, e_code);
      end
    end
  endtask
  task wr(input [2:0] a, input [19:0] d, input integer s);
    begin
      @(negedge clock);
      dacuc_host_i.send({1'h0, a, d}, 24, s);
      repeat (8) @(negedge clock);
    end
  endtask
  // Read frame, then a no-op frame that shifts the addressed word out
  task rd_chk(input [2:0] a, input [19:0] d);
    begin
      @(negedge clock);
      dacuc_host_i.send({1'h1, a, 20'h00000}, 24, 0);
      repeat (8) @(negedge clock);
      dacuc_host_i.send(24'h000000, 24, 0);
      repeat (8) @(negedge clock);
      n_checks = n_checks + 1;
      if (sdo_word !== {1'h1, a, d} || oe_seen !== ~e_ctrl[5]
          || serial_data_out_oe !== 1'h0) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t readback %h expected %h", $time, sdo_word, {1'h1, a, d});
      end
    end
  endtask
  task code_wr(input [19:0] d);
    begin
      e_in = d[19:2];
      if (!load_strobe_n && clear_strobe)
        e_code = e_in;
      wr(3'h1, d, 0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    rst_model;
    repeat (3) @(negedge clock);
    rstn = 1'h1;
    repeat (5) @(negedge clock);
    chk;
    for (i = 0; i < 8; i = i + 1) begin
      e_ctrl = (i == 7) ? 20'h0 : 20'(nxt()) & 20'h003FE;
      wr(3'h2, e_ctrl, i * 40);
      chk;
    end
    $display("done: control fields");
    load_strobe_n = 1'h0;
    code_wr(20'hFFFFF);
    chk;
    for (i = 0; i < 3; i = i + 1) begin
      code_wr(20'(nxt()));
      chk;
    end
    dacuc_host_i.send({4'h1, 20'h0}, 23, 0);
    repeat (8) @(negedge clock);
    chk;
    rd_chk(3'h1, {e_code, 2'h0});
    $display("done: synchronous update");
    load_strobe_n = 1'h1;
    code_wr(20'(nxt()));
    chk;
    load_strobe_n = 1'h0;
    e_code = e_in;
    repeat (8) @(negedge clock);
    chk;
    load_strobe_n = 1'h1;
    $display("done: asynchronous update");
    e_clr = 18'(nxt());
    wr(3'h3, {e_clr, 2'h3}, 0);
    chk;
    clear_strobe = 1'h0;
    e_code = e_clr;
    repeat (8) @(negedge clock);
    chk;
    load_strobe_n = 1'h0;
    code_wr(20'(nxt()));
    chk;
    load_strobe_n = 1'h1;
    @(negedge clock);
    clear_strobe = 1'h1;
    repeat (8) @(negedge clock);
    chk;
    code_wr(20'(nxt()));
    e_code = e_in;
    wr(3'h4, 20'h00001, 0);
    chk;
    e_code = e_clr;
    wr(3'h4, 20'h00002, 0);
    chk;
    rd_chk(3'h3, {e_clr, 2'h0});
    $display("done: clear");
    reset_pin_n = 1'h0;
    rst_model;
    load_strobe_n = 1'h0;
    wr(3'h1, 20'h3FFFC, 0);
    chk;
    reset_pin_n = 1'h1;
    repeat (8) @(negedge clock);
    chk;
    e_ctrl = 20'h00010;
    wr(3'h2, e_ctrl, 0);
    code_wr(20'(nxt()));
    chk;
    rd_chk(3'h2, e_ctrl);
    rst_model;
    wr(3'h4, 20'h00004, 0);
    chk;
    $display("done: reset");
    end_of_test;
  end
  initial begin
    #400000;
    err_count = err_count + 1;
    end_of_test;
  end
endmodule
